//--- pkg/pscd_pkg.sv
// Constants, opcodes, register map and types for the program and system control decoder.
package pscd_pkg;
  // Register map, byte addresses on the bus.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INSTR = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_PTR = 8'h0C;
  localparam logic [7:0] A_WREG = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_FSEL = 8'h18;
  localparam logic [7:0] A_MODE = 8'h1C;
  localparam logic [7:0] A_RTC = 8'h20;
  localparam logic [7:0] A_WDOG = 8'h24;
  localparam logic [7:0] A_PMADR = 8'h28;
  localparam logic [7:0] A_PMDAT = 8'h2C;
  // Control register bit positions.
  localparam int CT_GO = 0;
  localparam int CT_SAVE = 1;
  localparam int CT_PSWDT = 2;
  localparam int CT_WAKE = 3;
  // Status register bit positions.
  localparam int ST_C = 0;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_PA = 5;
  // Fixed opcodes and opcode prefixes.
  localparam logic [11:0] OP_RET = 12'h00C;
  localparam logic [11:0] OP_PAGED_RETURN = 12'h00D;
  localparam logic [11:0] OP_INTERRUPT_RETURN = 12'h00E;
  localparam logic [11:0] OP_INTERRUPT_RETURN_ADD_COUNTER = 12'h00F;
  localparam logic [11:0] OP_SLEEP = 12'h003;
  localparam logic [11:0] OP_PROGRAM_WORD_FETCH = 12'h041;
  localparam logic [3:0] PF_CALL = 4'h9;
  localparam logic [3:0] PF_LITERAL_RETURN = 4'h8;
  localparam logic [2:0] PF_JMP = 3'h5;
  localparam logic [8:0] PF_BANK = 9'h003;
  localparam logic [8:0] PF_PAGE = 9'h002;
  localparam logic [6:0] PF_MOVF = 7'h01;
  localparam logic [6:0] PF_ADDF = 7'h0F;
  localparam logic [3:0] PF_CLRB = 4'h4;
  localparam logic [3:0] PF_SETB = 4'h5;
  localparam logic [3:0] PF_SNB = 4'h6;
  localparam logic [3:0] PF_SB = 4'h7;
  // File register addresses.
  localparam logic [4:0] F_RTC = 5'h01;
  localparam logic [4:0] F_PTR = 5'h02;
  localparam logic [4:0] F_STATUS = 5'h03;
  localparam logic [4:0] F_FSEL = 5'h04;
  // Reset value of status and the pointer step sizes.
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [10:0] PC_STEP = 11'h001;
  localparam logic [10:0] PC_SKIP = 11'h002;
  // Cycle counts per instruction group, compatible and turbo.
  typedef struct packed {
    logic [2:0] compat;
    logic [2:0] turbo;
  } pscd_cyc_t;
  localparam pscd_cyc_t CY_ONE = '{3'h1, 3'h1};
  localparam pscd_cyc_t CY_BRANCH = '{3'h2, 3'h3};
  localparam pscd_cyc_t CY_FETCH = '{3'h1, 3'h4};
  localparam pscd_cyc_t CY_PCWR = '{3'h4, 3'h3};
  localparam pscd_cyc_t CY_SKIP = '{3'h2, 3'h2};
  localparam pscd_cyc_t CY_PCSKIP = '{3'h4, 3'h2};
  typedef enum logic [4:0] {
    CL_OTHER = 5'h00, CL_CALL = 5'h01, CL_JMP = 5'h02, CL_RET = 5'h03,
    CL_PAGED_RETURN = 5'h04, CL_INTERRUPT_RETURN = 5'h05, CL_INTERRUPT_RETURN_ADD_COUNTER = 5'h06, CL_LITERAL_RETURN = 5'h07,
    CL_BANK = 5'h08, CL_PROGRAM_WORD_FETCH = 5'h09, CL_PAGE = 5'h0A, CL_SLEEP = 5'h0B,
    CL_PCWR = 5'h0C, CL_PCADD = 5'h0D, CL_BCLR = 5'h0E, CL_BSET = 5'h0F,
    CL_SKIP = 5'h10
  } pscd_cls_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BUSY = 2'b01,
    S_HALT = 2'b10
  } pscd_state_t;
endpackage

//--- rtl/pscd_core.sv
// Program and system control instruction decoder and executor with a Wishbone slave.
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Contract
// - Call pushes next address, loads low byte, clears bit 8, page bits to 10:9.
// - Jump loads nine operand bits plus page bits; 2 cycles compatible, 3 turbo.
// - Plain return reloads the pointer from stack top, flags unchanged.
// - Paged return also copies stack bits 10:9 into the page bits.
// - Interrupt return restores W, status, file select, pointer; keeps timeout, powerdown.
// - Counter variant of interrupt return also adds W to the realtime counter.
// - Literal return puts immediate in W and pops the pointer, flags unchanged.
// - Bank select copies operand 2:0 into file select 7:5, one cycle.
// - Program word fetch reads memory at MODE:W into MODE:W; 1 or 4 cycles.
// - Page select writes operand 2:0 into status 7:5 in one cycle.
// - Power down clears watchdog, sets timeout, clears powerdown, prescaler, stops oscillator.
// - Carry is status bit 0 at file 03; clearing it clears carry.
// - Writing or adding into file 02 is a jump: 4 cycles compatible, 3 turbo.
// - Bit-test skip costs 1 cycle when false, 2 when it skips.
// - Always-true skip on pointer bit 0 skips; 4 cycles compatible, 2 turbo.
module pscd_core import pscd_pkg::*; #(
  parameter int STK_DEPTH = 8,
  parameter int PM_AW = 12
) (
  // System.
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Clocking mode strap, high selects turbo.
  input wire logic TURBO_STRAP,
  // Wishbone slave.
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Core side effects.
  output logic BUSY,
  output logic OSC_STOP,
  output logic PRESCALE_CLR
);
  localparam int SPW = $clog2(STK_DEPTH);

  logic ack_q, busy_q, osc_q, pclr_q, psw_q;
  logic [31:0] dat_q;
  logic [1:0] strap_q;
  logic cap_q, turbo_q;
  logic [1:0] fill_q;
  pscd_state_t state_q;
  logic [2:0] cnt_q;
  logic [11:0] instr_q;
  logic [10:0] pc_q;
  logic [7:0] w_q, st_q, fsr_q, realtime_counter_q, wdt_q;
  logic [3:0] mode_q;
  logic [7:0] sh_w_q, sh_st_q, sh_fsr_q;
  logic [10:0] sh_pc_q;
  logic [10:0] stk_q [STK_DEPTH];
  logic [SPW-1:0] sp_q;
  logic [11:0] pmem [2**PM_AW];
  logic [PM_AW-1:0] pmadr_q;

  // Bus decode.
  wire req = CYC_I & STB_I;
  wire wr_take = req & ack_q & WE_I;
  wire [31:0] wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  wire [31:0] wdat = DAT_I & wmask;
  wire wr_ctrl = wr_take & (ADR_I == A_CTRL);
  wire idle = (state_q == S_IDLE);
  wire go_acc = wr_ctrl & wdat[CT_GO] & idle & cap_q;
  wire wr_reg = wr_take & idle & ~go_acc;

  // Instruction field decode.
  wire [4:0] fa = instr_q[4:0];
  wire [2:0] bsel = instr_q[7:5];
  wire [10:0] pc_inc = pc_q + PC_STEP;
  wire [SPW-1:0] sp_top = sp_q - 1'b1;
  wire [10:0] tos = stk_q[sp_top];
  wire is_sb = instr_q[11:8] == PF_SB;
  wire is_snb = instr_q[11:8] == PF_SNB;
  pscd_cls_t cls;
  assign cls = (instr_q == OP_RET) ? CL_RET :
               (instr_q == OP_PAGED_RETURN) ? CL_PAGED_RETURN :
               (instr_q == OP_INTERRUPT_RETURN) ? CL_INTERRUPT_RETURN :
               (instr_q == OP_INTERRUPT_RETURN_ADD_COUNTER) ? CL_INTERRUPT_RETURN_ADD_COUNTER :
               (instr_q == OP_SLEEP) ? CL_SLEEP :
               (instr_q == OP_PROGRAM_WORD_FETCH) ? CL_PROGRAM_WORD_FETCH :
               (instr_q[11:8] == PF_CALL) ? CL_CALL :
               (instr_q[11:8] == PF_LITERAL_RETURN) ? CL_LITERAL_RETURN :
               (instr_q[11:9] == PF_JMP) ? CL_JMP :
               (instr_q[11:3] == PF_BANK) ? CL_BANK :
               (instr_q[11:3] == PF_PAGE) ? CL_PAGE :
               (instr_q[11:5] == PF_MOVF && fa == F_PTR) ? CL_PCWR :
               (instr_q[11:5] == PF_ADDF && fa == F_PTR) ? CL_PCADD :
               (instr_q[11:8] == PF_CLRB) ? CL_BCLR :
               (instr_q[11:8] == PF_SETB) ? CL_BSET :
               (is_sb | is_snb) ? CL_SKIP : CL_OTHER;
  wire [7:0] fval = (fa == F_PTR) ? pc_q[7:0] :
                    (fa == F_STATUS) ? st_q :
                    (fa == F_FSEL) ? fsr_q :
                    (fa == F_RTC) ? realtime_counter_q : 8'h00;
  wire skip = is_sb ? fval[bsel] : ~fval[bsel];
  wire [11:0] fetch_adr = {mode_q, w_q};
  wire [11:0] pword = pmem[fetch_adr[PM_AW-1:0]];

  // Execution results.
  logic [10:0] pc_d;
  logic [7:0] w_d, st_d, fsr_d, realtime_counter_d;
  logic [3:0] mode_d;
  logic push, pop, stop;
  pscd_cyc_t cy;
  always_comb begin
    pc_d = pc_inc;
    w_d = w_q;
    st_d = st_q;
    fsr_d = fsr_q;
    realtime_counter_d = realtime_counter_q;
    mode_d = mode_q;
    push = 1'b0;
    pop = 1'b0;
    stop = 1'b0;
    cy = CY_ONE;
    unique case (cls)
      CL_CALL: begin
        push = 1'b1;
        pc_d = {st_q[ST_PA+1:ST_PA], 1'b0, instr_q[7:0]};
        cy = CY_BRANCH;
      end
      CL_JMP: begin
        pc_d = {st_q[ST_PA+1:ST_PA], instr_q[8:0]};
        cy = CY_BRANCH;
      end
      CL_RET: begin
        pop = 1'b1;
        pc_d = tos;
        cy = CY_BRANCH;
      end
      CL_PAGED_RETURN: begin
        pop = 1'b1;
        pc_d = tos;
        st_d[ST_PA+1:ST_PA] = tos[10:9];
        cy = CY_BRANCH;
      end
      CL_INTERRUPT_RETURN, CL_INTERRUPT_RETURN_ADD_COUNTER: begin
        pc_d = sh_pc_q;
        w_d = sh_w_q;
        fsr_d = sh_fsr_q;
        st_d = {sh_st_q[7:ST_TO+1], st_q[ST_TO:ST_PD], sh_st_q[ST_PD-1:0]};
        if (cls == CL_INTERRUPT_RETURN_ADD_COUNTER) begin
          realtime_counter_d = realtime_counter_q + w_q;
        end
        cy = CY_BRANCH;
      end
      CL_LITERAL_RETURN: begin
        pop = 1'b1;
        w_d = instr_q[7:0];
        pc_d = tos;
        cy = CY_BRANCH;
      end
      CL_BANK: fsr_d[7:5] = instr_q[2:0];
      CL_PROGRAM_WORD_FETCH: begin
        mode_d = pword[11:8];
        w_d = pword[7:0];
        cy = CY_FETCH;
      end
      CL_PAGE: st_d[7:ST_PA] = instr_q[2:0];
      CL_SLEEP: begin
        st_d[ST_TO] = 1'b1;
        st_d[ST_PD] = 1'b0;
        stop = 1'b1;
      end
      CL_PCWR: begin
        pc_d = {st_q[ST_PA+1:ST_PA], 1'b0, w_q};
        cy = CY_PCWR;
      end
      CL_PCADD: begin
        pc_d = {st_q[ST_PA+1:ST_PA], 1'b0, 8'(pc_inc[7:0] + w_q)};
        cy = CY_PCWR;
      end
      CL_BCLR, CL_BSET: begin
        if (fa == F_STATUS && bsel != ST_TO && bsel != ST_PD) begin
          st_d[bsel] = (cls == CL_BSET);
        end else if (fa == F_FSEL) begin
          fsr_d[bsel] = (cls == CL_BSET);
        end
      end
      CL_SKIP: begin
        if (skip) begin
          pc_d = pc_q + PC_SKIP;
          cy = (fa == F_PTR) ? CY_PCSKIP : CY_SKIP;
        end
      end
      CL_OTHER: cy = CY_ONE;
    endcase
  end
  wire [2:0] ncyc = turbo_q ? cy.turbo : cy.compat;

  // Strap synchroniser and one-time capture after reset release.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      strap_q <= 2'b00;
      fill_q <= 2'b00;
      cap_q <= 1'b0;
      turbo_q <= 1'b0;
    end else begin
      strap_q <= {strap_q[0], TURBO_STRAP};
      fill_q <= {fill_q[0], 1'b1};
      // Capture waits until both stages hold the strap rather than their reset value.
      if (fill_q[1] && !cap_q) begin
        cap_q <= 1'b1;
        turbo_q <= strap_q[1];
      end
    end
  end

  // Bus answer and read data.
  wire [31:0] rd_mux = (ADR_I == A_CTRL) ? {29'h0, psw_q, 2'b00} :
                       (ADR_I == A_INSTR) ? {20'h0, instr_q} :
                       (ADR_I == A_STAT) ? {29'h0, osc_q, turbo_q, busy_q} :
                       (ADR_I == A_PTR) ? {21'h0, pc_q} :
                       (ADR_I == A_WREG) ? {24'h0, w_q} :
                       (ADR_I == A_STATUS) ? {24'h0, st_q} :
                       (ADR_I == A_FSEL) ? {24'h0, fsr_q} :
                       (ADR_I == A_MODE) ? {28'h0, mode_q} :
                       (ADR_I == A_RTC) ? {24'h0, realtime_counter_q} :
                       (ADR_I == A_WDOG) ? {24'h0, wdt_q} :
                       (ADR_I == A_PMADR) ? {{(32-PM_AW){1'b0}}, pmadr_q} : 32'h0;
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= rd_mux;
      end
    end
  end

  // Sequencer.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
      osc_q <= 1'b0;
      pclr_q <= 1'b0;
    end else begin
      pclr_q <= go_acc & stop & psw_q;
      unique case (state_q)
        S_IDLE: if (go_acc) begin
          state_q <= S_BUSY;
          cnt_q <= ncyc;
          busy_q <= 1'b1;
        end
        S_BUSY: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            busy_q <= 1'b0;
            state_q <= osc_q ? S_HALT : S_IDLE;
          end
        end
        S_HALT: if (wr_ctrl & wdat[CT_WAKE]) begin
          state_q <= S_IDLE;
          osc_q <= 1'b0;
        end
        default: state_q <= S_IDLE;
      endcase
      if (go_acc & stop) begin
        osc_q <= 1'b1;
      end
    end
  end

  // Architectural state: execution wins over bus writes in the same cycle.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      instr_q <= 12'h000;
      pc_q <= 11'h000;
      w_q <= 8'h00;
      st_q <= RST_STATUS;
      fsr_q <= 8'h00;
      realtime_counter_q <= 8'h00;
      mode_q <= 4'h0;
      wdt_q <= 8'h00;
      sp_q <= '0;
      psw_q <= 1'b0;
      pmadr_q <= '0;
      sh_w_q <= 8'h00;
      sh_st_q <= 8'h00;
      sh_fsr_q <= 8'h00;
      sh_pc_q <= 11'h000;
    end else if (go_acc) begin
      pc_q <= pc_d;
      w_q <= w_d;
      st_q <= st_d;
      fsr_q <= fsr_d;
      realtime_counter_q <= realtime_counter_d;
      mode_q <= mode_d;
      wdt_q <= stop ? 8'h00 : wdt_q + 8'h01;
      if (push) begin
        stk_q[sp_q] <= pc_inc;
        sp_q <= sp_q + 1'b1;
      end else if (pop) begin
        sp_q <= sp_top;
      end
    end else begin
      // The count stays at zero from power-down entry until wake.
      if (!osc_q) begin
        wdt_q <= wdt_q + 8'h01;
      end
      if (wr_ctrl) begin
        psw_q <= wdat[CT_PSWDT];
      end
      if (wr_reg) begin
        unique case (ADR_I)
          A_CTRL: if (wdat[CT_SAVE]) begin
            sh_w_q <= w_q;
            sh_st_q <= st_q;
            sh_fsr_q <= fsr_q;
            sh_pc_q <= pc_q;
          end
          A_INSTR: instr_q <= wdat[11:0];
          A_PTR: pc_q <= wdat[10:0];
          A_WREG: w_q <= wdat[7:0];
          A_STATUS: st_q <= wdat[7:0];
          A_FSEL: fsr_q <= wdat[7:0];
          A_MODE: mode_q <= wdat[3:0];
          A_RTC: realtime_counter_q <= wdat[7:0];
          A_PMADR: pmadr_q <= wdat[PM_AW-1:0];
          A_PMDAT: pmem[pmadr_q] <= wdat[11:0];
          default: ;
        endcase
      end
    end
  end

  assign DAT_O = dat_q;
  assign ACK_O = ack_q;
  assign BUSY = busy_q;
  assign OSC_STOP = osc_q;
  assign PRESCALE_CLR = pclr_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_branch_run;
    busy_q [*2] ##1 !busy_q;
  endsequence
  sequence s_turbo_run;
    busy_q [*3] ##1 !busy_q;
  endsequence
  a_call_target: assert property (go_acc && cls == CL_CALL |=>
    pc_q == {$past(st_q[6:5]), 1'b0, $past(instr_q[7:0])} && stk_q[$past(sp_q)] == $past(pc_inc))
    else $error("call target or pushed address wrong");
  a_branch_compat: assert property (go_acc && (cls == CL_JMP || cls == CL_CALL) && !turbo_q
    |=> s_branch_run) else $error("branch not two cycles");
  a_branch_turbo: assert property (go_acc && cls == CL_JMP && turbo_q |=> s_turbo_run)
    else $error("branch not three cycles in turbo");
  a_ret_flags: assert property (go_acc && cls == CL_RET |=> pc_q == $past(tos) && $stable(st_q))
    else $error("plain return wrong");
  a_paged_return_page: assert property (go_acc && cls == CL_PAGED_RETURN |=> st_q[6:5] == $past(tos[10:9]))
    else $error("paged return page bits wrong");
  a_interrupt_return_keep: assert property (go_acc && (cls == CL_INTERRUPT_RETURN || cls == CL_INTERRUPT_RETURN_ADD_COUNTER) |=>
    st_q[4:3] == $past(st_q[4:3]) && w_q == $past(sh_w_q) && pc_q == $past(sh_pc_q))
    else $error("interrupt return restore wrong");
  a_interrupt_return_add_counter_add: assert property (go_acc && cls == CL_INTERRUPT_RETURN_ADD_COUNTER |=>
    realtime_counter_q == $past(realtime_counter_q) + $past(w_q)) else $error("counter add wrong");
  a_literal_return_lit: assert property (go_acc && cls == CL_LITERAL_RETURN |=> w_q == $past(instr_q[7:0]))
    else $error("literal return value wrong");
  a_bank_fsel: assert property (go_acc && cls == CL_BANK |=>
    fsr_q[7:5] == $past(instr_q[2:0]) ##1 !busy_q) else $error("bank select wrong");
  a_fetch_turbo: assert property (go_acc && cls == CL_PROGRAM_WORD_FETCH && turbo_q |=>
    busy_q [*4] ##1 !busy_q) else $error("fetch not four cycles");
  a_page_bits: assert property (go_acc && cls == CL_PAGE |=> st_q[7:5] == $past(instr_q[2:0]))
    else $error("page select wrong");
  a_sleep_flags: assert property (go_acc && cls == CL_SLEEP |=>
    st_q[ST_TO] && !st_q[ST_PD] && wdt_q == 8'h00 && osc_q)
    else $error("power down effects wrong");
  a_pcwr_len: assert property (go_acc && cls == CL_PCWR && !turbo_q |=>
    busy_q [*4] ##1 !busy_q) else $error("pointer write not four cycles");
  a_skip_false: assert property (go_acc && cls == CL_SKIP && !skip |=> busy_q ##1 !busy_q)
    else $error("false skip not one cycle");
  a_mode_hold: assert property (cap_q |=> $stable(turbo_q))
    else $error("clocking mode changed");
endmodule

//--- verification/pscd_wb_host.sv
// Wishbone classic master that stands in for the software side of the decoder.
`timescale 1ns/1ps
module pscd_wb_host (
  // Bus clock.
  input wire logic clk,
  // Slave answer.
  input wire logic ack,
  // Master request.
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end

  // Holds the request until ack is sampled high, then idles the bus for a cycle.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~d;
    @(posedge clk);
  endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the program and system control decoder.
`timescale 1ns/1ps
module testbench import pscd_pkg::*;;
  logic clk_sys, sys_rst, turbo_strap, turbo;
  logic cyc, stb, we, ack, busy, osc_stop, ps_clr;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r, ctl;
  logic [10:0] p, pp;
  logic [7:0] w, k;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int busy_n = 0;
  int pulses = 0;
  logic [31:0] eq[$], mq[$];
  string nq[$];
  logic [2:0] cq[$];

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  pscd_core #(.STK_DEPTH(8), .PM_AW(6)) uut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .TURBO_STRAP(turbo_strap),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
    .DAT_O(rdat), .ACK_O(ack), .BUSY(busy), .OSC_STOP(osc_stop), .PRESCALE_CLR(ps_clr)
  );

  pscd_wb_host host (
    .clk(clk_sys), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(wdat)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [2:0] cy(input pscd_cyc_t c);
    return turbo ? c.turbo : c.compat;
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp_data(input string n, input logic [31:0] e, g, m);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e & m, g & m);
    end
  endtask

  task automatic cmp_count(input string n, input int e, input int g);
    checks_done++;
    if (e != g) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, m);
    nq.push_back(n);
    eq.push_back(e);
    mq.push_back(m);
    host.xfer(1'b0, a, 32'h0);
  endtask

  // Notes the busy length, starts the instruction and waits for it to finish.
  task automatic run(input logic [11:0] op, input logic [2:0] n);
    wr(A_INSTR, {20'h0, op});
    cq.push_back(n);
    wr(A_CTRL, ctl | 32'h1);
    while (busy === 1'b1) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict;
    end
  end

  // Read data is taken at the ack edge and matched to the oldest noted value.
  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0 && eq.size() > 0) begin
      cmp_data(nq.pop_front(), eq.pop_front(), rdat, mq.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    if (ps_clr === 1'b1) pulses++;
    if (busy === 1'b1) begin
      busy_n++;
    end else if (busy_n > 0) begin
      cmp_count("busy cycles", int'(cq.pop_front()), busy_n);
      busy_n = 0;
    end
  end

  initial begin
    sys_rst = 1'b1;
    turbo_strap = 1'b0;
    turbo = 1'b0;
    r = 32'h6399;
    ctl = 32'h0;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      turbo_strap <= m[0];
      turbo = m[0];
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd("strap", A_STAT, {30'h0, turbo, 1'b0}, 32'h2);
      rd("unmapped", 8'h3C, 32'h0, 32'hFFFFFFFF);
      r = lfsr(r);
      p = r[10:0];
      pp = p + PC_STEP;
      k = r[18:11];
      wr(A_STATUS, 32'h41);
      wr(A_PTR, p);
      run({PF_CALL, k}, cy(CY_BRANCH));
      rd("call target", A_PTR, {21'h0, 2'b10, 1'b0, k}, 32'h7FF);
      run({PF_LITERAL_RETURN, r[26:19]}, cy(CY_BRANCH));
      rd("literal", A_WREG, r[26:19], 32'hFF);
      rd("literal return", A_PTR, pp, 32'h7FF);
      wr(A_PTR, p);
      run({PF_CALL, k}, cy(CY_BRANCH));
      run(OP_RET, cy(CY_BRANCH));
      rd("plain return", A_PTR, pp, 32'h7FF);
      rd("flags kept", A_STATUS, 32'h41, 32'hE1);
      wr(A_PTR, p);
      run({PF_CALL, k}, cy(CY_BRANCH));
      run(OP_PAGED_RETURN, cy(CY_BRANCH));
      rd("paged return", A_PTR, pp, 32'h7FF);
      rd("paged bits", A_STATUS, {pp[10:9], 5'h0}, 32'h60);
      run({PF_JMP, r[27:19]}, cy(CY_BRANCH));
      rd("jump target", A_PTR, {pp[10:9], r[27:19]}, 32'h7FF);
      $display("test branches done");
      wr(A_FSEL, r[7:0]);
      run({PF_BANK, r[30:28]}, cy(CY_ONE));
      rd("bank", A_FSEL, {r[30:28], r[4:0]}, 32'hFF);
      run({PF_PAGE, r[2:0]}, cy(CY_ONE));
      rd("page", A_STATUS, {r[2:0], 5'h0}, 32'hE0);
      wr(A_STATUS, 32'h01);
      run({PF_CLRB, 3'h0, F_STATUS}, cy(CY_ONE));
      rd("carry", A_STATUS, 32'h0, 32'h01);
      wr(A_STATUS, 32'h01);
      wr(A_PTR, p);
      run({PF_SB, 3'h0, F_STATUS}, cy(CY_SKIP));
      run({PF_SNB, 3'h0, F_STATUS}, cy(CY_ONE));
      rd("skip", A_PTR, p + PC_SKIP + PC_STEP, 32'h7FF);
      pp = p + 11'h003;
      run({pp[0] ? PF_SB : PF_SNB, 3'h0, F_PTR}, cy(CY_PCSKIP));
      rd("counter skip", A_PTR, pp + PC_SKIP, 32'h7FF);
      w = r[7:0];
      wr(A_WREG, w);
      run(12'h022, cy(CY_PCWR));
      rd("counter move", A_PTR, w, 32'hFF);
      run(12'h1E2, cy(CY_PCWR));
      rd("counter add", A_PTR, 8'(w + 8'h01 + w), 32'hFF);
      $display("test skips and counter writes done");
      r = lfsr(r);
      wr(A_PMADR, r[5:0]);
      wr(A_PMDAT, r[27:16]);
      wr(A_MODE, 32'h0);
      wr(A_WREG, r[5:0]);
      run(OP_PROGRAM_WORD_FETCH, cy(CY_FETCH));
      rd("fetch high", A_MODE, r[27:24], 32'hF);
      rd("fetch low", A_WREG, r[23:16], 32'hFF);
      wr(A_WREG, r[7:0]);
      wr(A_STATUS, 32'h61);
      wr(A_FSEL, r[15:8]);
      wr(A_PTR, p);
      wr(A_CTRL, 32'h2);
      wr(A_WREG, r[31:24]);
      wr(A_STATUS, 32'h0);
      wr(A_FSEL, 32'h0);
      wr(A_PTR, 32'h0);
      wr(A_RTC, r[23:16]);
      run(OP_INTERRUPT_RETURN_ADD_COUNTER, cy(CY_BRANCH));
      rd("counter sum", A_RTC, 8'(r[23:16] + r[31:24]), 32'hFF);
      rd("restored w", A_WREG, r[7:0], 32'hFF);
      rd("restored fsel", A_FSEL, r[15:8], 32'hFF);
      rd("restored ptr", A_PTR, p, 32'h7FF);
      rd("restored status", A_STATUS, 32'h61, 32'hE1);
      wr(A_WREG, 32'h0);
      run(OP_INTERRUPT_RETURN, cy(CY_BRANCH));
      rd("restored w again", A_WREG, r[7:0], 32'hFF);
      ctl = 32'h4;
      wr(A_CTRL, ctl);
      run(OP_SLEEP, cy(CY_ONE));
      rd("sleep flags", A_STATUS, 32'h10, 32'h18);
      rd("halted", A_STAT, 32'h4, 32'h4);
      cmp_data("osc stop pin", 32'h1, {31'h0, osc_stop}, 32'h1);
      rd("watchdog", A_WDOG, 32'h0, 32'hFF);
      ctl = 32'h0;
      wr(A_CTRL, 32'h8);
      cmp_data("osc stop pin", 32'h0, {31'h0, osc_stop}, 32'h1);
      $display("test returns and power down done");
    end
    cmp_count("prescaler clears", 2, pulses);
    give_verdict;
  end
endmodule
